/* File: src/gpw_map.svh */
/*
 * register offsets, reset values, masks and port indices of the gpio port block.
 * assumes inclusion by bare name from the design module and the bench.
 */
`ifndef GPW_MAP_SVH
`define GPW_MAP_SVH

// ****************************************************************
// register offsets (word index on the data memory port)
// ****************************************************************
`define GPW_PORT_STRIDE 5'h03
`define GPW_OFS_DATA    5'h00
`define GPW_OFS_DIR     5'h01
`define GPW_OFS_PULL    5'h02
`define GPW_OFS_WAKE    5'h12
`define GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT    5'h13
`define GPW_OFS_SRC0    5'h14
`define GPW_OFS_SRC1    5'h15
`define GPW_OFS_SRC2    5'h16

// ****************************************************************
// reset values and masks
// ****************************************************************
`define GPW_RST_DATA    8'hFF
`define GPW_RST_DIR     8'hFF
`define GPW_RST_ZERO    8'h00
`define GPW_MASK_FULL   8'hFF
`define GPW_MASK_PD     8'h03
`define GPW_MASK_LOW_VOLTAGE_PULLUP_SELECT   8'h01
`define GPW_MASK_SRC1   8'h3F

// ****************************************************************
// port indices
// ****************************************************************
`define GPW_PA 0
`define GPW_PB 1
`define GPW_PC 2
`define GPW_PD 3
`define GPW_PE 4
`define GPW_PF 5

`endif

/* File: src/gpw_pkg.sv */
/*
 * types shared by the gpio port block.
 * assumes gpw_map.svh is on the include path.
 */
package gpw_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } gpw_bus_req_t;

  typedef enum logic [1:0] {
    GPW_LVL0 = 2'b00,
    GPW_LVL1 = 2'b01,
    GPW_LVL2 = 2'b10,
    GPW_LVL3 = 2'b11
  } gpw_level_t;

endpackage

/* File: src/gpw_port.sv */
/*
 * gpio port logic: direction, output latches, pull-high, port a wake-up
 * and source drive level selection for six ports (pd has two pins).
 * assumes a core that writes and reads registers on a data memory port in
 * the i_clk domain, and pad cells that resolve the pin from out and enable.
 */
`timescale 1ns/1ps
`include "gpw_map.svh"

module gpw_port
  import gpw_pkg::*;
#(
  parameter int NPORT = 6
) (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_b,
  // register port
  input  wire gpw_bus_req_t                 i_bus,
  output logic [7:0]                        o_rdata,
  // mode and pin mux
  input  wire logic                         i_low_power,
  input  wire logic [NPORT-1:0][7:0]        i_open_drain,
  // pins
  input  wire logic [NPORT-1:0][7:0]        i_pin,
  output logic [NPORT-1:0][7:0]             o_pin,
  output logic [NPORT-1:0][7:0]             o_pin_oe,
  // pad controls and wake-up request
  output logic [NPORT-1:0][7:0]             o_pullup_en,
  output logic [NPORT-1:0][7:0]             o_pullup_strong,
  output gpw_level_t [NPORT-1:0][7:0]       o_src_level,
  output logic                              o_wake_req
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_ff1_reg;
  logic rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_ff1_reg <= 1'b0;
      rst_b       <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rst_b       <= rst_ff1_reg;
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [NPORT-1:0][7:0] pin_ff1_reg;
  logic [NPORT-1:0][7:0] pin_sync_reg;
  logic [7:0]            pa_prev_reg;

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_ff1_reg  <= '0;
      pin_sync_reg <= '0;
      pa_prev_reg  <= '0;
    end else begin
      pin_ff1_reg  <= i_pin;
      pin_sync_reg <= pin_ff1_reg;
      pa_prev_reg  <= pin_sync_reg[`GPW_PA];
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [NPORT-1:0][7:0] data_reg;
  logic [NPORT-1:0][7:0] dir_reg;
  logic [NPORT-1:0][7:0] pu_reg;
  logic [7:0]            wake_en_reg;
  logic                  low_voltage_pullup_select_reg;
  logic [7:0]            src0_reg;
  logic [7:0]            src1_reg;
  logic [7:0]            src2_reg;
  logic [NPORT-1:0][7:0] port_mask;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      port_mask[p] = (p == `GPW_PD) ? `GPW_MASK_PD : `GPW_MASK_FULL;
    end
  end

  function automatic logic [4:0] port_ofs(input int p, input logic [4:0] f);
    port_ofs = 5'(p * `GPW_PORT_STRIDE) + f;
  endfunction

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) begin
        data_reg[p] <= `GPW_RST_DATA;
        dir_reg[p]  <= `GPW_RST_DIR;
        pu_reg[p]   <= `GPW_RST_ZERO;
      end
    end else if (i_bus.wr) begin
      for (int p = 0; p < NPORT; p++) begin
        if (i_bus.addr == port_ofs(p, `GPW_OFS_DATA)) begin
          data_reg[p] <= i_bus.wdata;
        end
        if (i_bus.addr == port_ofs(p, `GPW_OFS_DIR)) begin
          dir_reg[p] <= i_bus.wdata | ~port_mask[p];
        end
        if (i_bus.addr == port_ofs(p, `GPW_OFS_PULL)) begin
          pu_reg[p] <= i_bus.wdata & port_mask[p];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_en_reg <= `GPW_RST_ZERO;
      low_voltage_pullup_select_reg    <= 1'b0;
      src0_reg    <= `GPW_RST_ZERO;
      src1_reg    <= `GPW_RST_ZERO;
      src2_reg    <= `GPW_RST_ZERO;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        `GPW_OFS_WAKE: wake_en_reg <= i_bus.wdata;
        `GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT: low_voltage_pullup_select_reg    <= i_bus.wdata[0];
        `GPW_OFS_SRC0: src0_reg    <= i_bus.wdata;
        `GPW_OFS_SRC1: src1_reg    <= i_bus.wdata & `GPW_MASK_SRC1;
        `GPW_OFS_SRC2: src2_reg    <= i_bus.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    for (int p = 0; p < NPORT; p++) begin
      if (i_bus.addr == port_ofs(p, `GPW_OFS_DATA)) begin
        rdata_next = ((dir_reg[p] & pin_sync_reg[p])
                     | (~dir_reg[p] & data_reg[p])) & port_mask[p];
      end
      if (i_bus.addr == port_ofs(p, `GPW_OFS_DIR)) begin
        rdata_next = dir_reg[p] & port_mask[p];
      end
      if (i_bus.addr == port_ofs(p, `GPW_OFS_PULL)) begin
        rdata_next = pu_reg[p];
      end
    end
    case (i_bus.addr)
      `GPW_OFS_WAKE: rdata_next = wake_en_reg;
      `GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT: rdata_next = {7'h00, low_voltage_pullup_select_reg};
      `GPW_OFS_SRC0: rdata_next = src0_reg;
      `GPW_OFS_SRC1: rdata_next = src1_reg;
      `GPW_OFS_SRC2: rdata_next = src2_reg;
      default: ;
    endcase
  end

  // read data trails the address by one edge; unmapped reads give zero
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end

  // ****************************************************************
  // source level field per pin group
  // ****************************************************************
  logic [NPORT-1:0][1:0] src_lo;
  logic [NPORT-1:0][1:0] src_hi;

  always_comb begin
    src_lo = '0;
    src_hi = '0;
    src_lo[`GPW_PA] = src0_reg[1:0];
    src_hi[`GPW_PA] = src0_reg[3:2];
    src_lo[`GPW_PB] = src0_reg[5:4];
    src_hi[`GPW_PB] = src0_reg[7:6];
    src_lo[`GPW_PC] = src1_reg[1:0];
    src_hi[`GPW_PC] = src1_reg[3:2];
    src_lo[`GPW_PD] = src1_reg[5:4];
    src_hi[`GPW_PD] = src1_reg[5:4];
    src_lo[`GPW_PE] = src2_reg[1:0];
    src_hi[`GPW_PE] = src2_reg[3:2];
    src_lo[`GPW_PF] = src2_reg[5:4];
    src_hi[`GPW_PF] = src2_reg[7:6];
  end

  // ****************************************************************
  // pad controls
  // ****************************************************************
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_pin           <= '0;
      o_pin_oe        <= '0;
      o_pullup_en     <= '0;
      o_pullup_strong <= '0;
      o_src_level     <= '{default: GPW_LVL0};
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        for (int b = 0; b < 8; b++) begin
          // inputs never driven
          // open drain only pulls low, so the pull-high can lift it
          o_pin[p][b]    <= data_reg[p][b] & ~i_open_drain[p][b];
          o_pin_oe[p][b] <= ~dir_reg[p][b] & port_mask[p][b]
                            & ~(i_open_drain[p][b] & data_reg[p][b]);
          o_pullup_en[p][b] <= pu_reg[p][b]
                               & (dir_reg[p][b] | i_open_drain[p][b]);
          o_pullup_strong[p][b] <= low_voltage_pullup_select_reg & pu_reg[p][b]
                                   & (dir_reg[p][b] | i_open_drain[p][b]);
          if (!dir_reg[p][b] && !i_open_drain[p][b] && port_mask[p][b]) begin
            o_src_level[p][b] <= gpw_level_t'(b < 4 ? src_lo[p] : src_hi[p]);
          end else begin
            o_src_level[p][b] <= GPW_LVL0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // port a wake-up
  // ****************************************************************
  logic [7:0] pa_fall;

  assign pa_fall = pa_prev_reg & ~pin_sync_reg[`GPW_PA]
                   & dir_reg[`GPW_PA] & ~i_open_drain[`GPW_PA];

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_wake_req <= 1'b0;
    end else begin
      o_wake_req <= i_low_power & |(pa_fall & wake_en_reg);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_pull_gate;
    @(posedge i_clk) disable iff (!rst_b)
      1'b1 |=> (o_pullup_en & ~($past(pu_reg)
               & ($past(dir_reg) | $past(i_open_drain)))) == '0;
  endproperty
  a_pull_gate: assert property (p_pull_gate)
    else $error("pull-high on a pin that is a push-pull output");

  property p_dir_reset;
    @(posedge i_clk) $rose(rst_b) |-> dir_reg == '1 && pu_reg == '0;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction or pull-high not at reset value");

  property p_low_voltage_pullup_select_read;
    @(posedge i_clk) disable iff (!rst_b)
      i_bus.addr == `GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT |=> o_rdata[7:1] == 7'h00
                                     && o_rdata[0] == $past(low_voltage_pullup_select_reg);
  endproperty
  a_low_voltage_pullup_select_read: assert property (p_low_voltage_pullup_select_read)
    else $error("low-voltage pull-high register read wrong");

  property p_strong_gate;
    @(posedge i_clk) disable iff (!rst_b)
      1'b1 |=> o_pullup_strong
               == (o_pullup_en & {(NPORT*8){$past(low_voltage_pullup_select_reg)}});
  endproperty
  a_strong_gate: assert property (p_strong_gate)
    else $error("strong pull-high does not follow select and pull-high");

  property p_wake_fire;
    @(posedge i_clk) disable iff (!rst_b)
      i_low_power && |(pa_fall & wake_en_reg) |=> o_wake_req;
  endproperty
  a_wake_fire: assert property (p_wake_fire)
    else $error("enabled falling edge gave no wake-up");

  property p_wake_quiet;
    @(posedge i_clk) disable iff (!rst_b)
      !i_low_power || (pa_fall & wake_en_reg) == 8'h00 |=> !o_wake_req;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet)
    else $error("wake-up without enabled edge in low power");

  property p_latch_read;
    @(posedge i_clk) disable iff (!rst_b)
      i_bus.addr == port_ofs(`GPW_PA, `GPW_OFS_DATA) && !dir_reg[`GPW_PA][0]
      |=> o_rdata[0] == $past(data_reg[`GPW_PA][0]);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("output pin read did not return latch");

  property p_src_input;
    @(posedge i_clk) disable iff (!rst_b)
      dir_reg[`GPW_PA][0] |=> o_src_level[`GPW_PA][0] == GPW_LVL0;
  endproperty
  a_src_input: assert property (p_src_input)
    else $error("source level applied to an input pin");

  property p_latch_hold;
    @(posedge i_clk) disable iff (!rst_b)
      !(i_bus.wr && i_bus.addr == port_ofs(`GPW_PB, `GPW_OFS_DATA))
      |=> $stable(data_reg[`GPW_PB]);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("output latch changed without a write");

  property p_input_undriven;
    @(posedge i_clk) disable iff (!rst_b)
      1'b1 |=> (o_pin_oe & $past(dir_reg)) == '0;
  endproperty
  a_input_undriven: assert property (p_input_undriven)
    else $error("input pin driven");

endmodule

/* File: tb/gpw_pin_model.sv */
/*
 * external switches and loads on the port pins.
 * assumes the bench drives switch levels and knows pad drive and pull-high.
 */
`timescale 1ns/1ps

module gpw_pin_model
#(
  parameter int NPORT = 6
) (
  // pad side of the block
  input  wire logic [NPORT-1:0][7:0] i_out,
  input  wire logic [NPORT-1:0][7:0] i_oe,
  input  wire logic [NPORT-1:0][7:0] i_pull,
  // switches from the bench
  input  wire logic [NPORT-1:0][7:0] i_sw,
  input  wire logic [NPORT-1:0][7:0] i_sw_on,
  input  wire logic                  i_clash,
  // resolved pin levels
  output logic      [NPORT-1:0][7:0] o_level
);
  // ****************************************************************
  // pin resolution
  // ****************************************************************
  logic [NPORT-1:0][7:0] drv;

  // a clash lets a strong load win over the pad, to expose latch reads
  assign drv = i_clash ? '0 : i_oe;
  // a floating pin shows the inverse of the switch so no stale value passes
  assign o_level = (drv & i_out) | (~drv & i_sw_on & i_sw)
                 | (~drv & ~i_sw_on & (i_pull | ~i_sw));
endmodule

/* File: tb/gpw_port_tb.sv */
/*
 * self-checking bench of the gpio port block.
 * assumes gpw_map.svh on the include path and the pin model beside it.
 */
`timescale 1ns/1ps
`include "gpw_map.svh"

module gpw_port_tb;
  import gpw_pkg::*;
  localparam int NP = 6;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  gpw_bus_req_t          bus = '0;
  logic                  lowp = 1'b0;
  logic                  clash = 1'b0;
  logic [NP-1:0][7:0]    od = '0;
  logic [NP-1:0][7:0]    sw = '0;
  logic [NP-1:0][7:0]    sw_on = '0;
  logic [NP-1:0][7:0]    pin, opin, oe, pu, pus;
  gpw_level_t [NP-1:0][7:0] lvl;
  logic [7:0]            rdata;
  logic                  wake;
  int                    failures = 0;
  int                    n_checks = 0;
  int                    cyc = 0;

  always #25 clk = ~clk;

  gpw_port #(.NPORT(NP)) dut (.i_clk(clk), .i_rst_b(rst_b), .i_bus(bus),
    .o_rdata(rdata), .i_low_power(lowp), .i_open_drain(od), .i_pin(pin),
    .o_pin(opin), .o_pin_oe(oe), .o_pullup_en(pu), .o_pullup_strong(pus),
    .o_src_level(lvl), .o_wake_req(wake));

  gpw_pin_model #(.NPORT(NP)) u_pins (.i_out(opin), .i_oe(oe), .i_pull(pu),
    .i_sw(sw), .i_sw_on(sw_on), .i_clash(clash), .o_level(pin));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    @(negedge clk);
    chk(rdata, exp);
  endtask

  // register write plus output flop, and the pin synchroniser
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task report_and_stop;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int p = 0; p < NP; p++) begin
      rd(5'(3 * p + 1), (p == 3) ? 8'h03 : 8'hFF);
      rd(5'(3 * p + 2), 8'h00);
      chk(oe[p], 8'h00);
    end
    rd(`GPW_OFS_WAKE, 8'h00);
    rd(`GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT, 8'h00);
    for (int i = 0; i < 3; i++) rd(5'(`GPW_OFS_SRC0 + i), 8'h00);
  endtask

  task automatic t_regs;
    wr(`GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT, 8'hFF);
    rd(`GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT, 8'h01);
    wr(`GPW_OFS_SRC1, 8'hFF);
    rd(`GPW_OFS_SRC1, 8'h3F);
    wr(`GPW_OFS_WAKE, 8'hA5);
    rd(`GPW_OFS_WAKE, 8'hA5);
    wr(5'h1F, 8'hFF);
    rd(5'h1F, 8'h00);
    wr(`GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT, 8'h00);
    wr(`GPW_OFS_WAKE, 8'h00);
  endtask

  task automatic t_src;
    logic [23:0] v;
    logic [7:0]  m;
    logic [7:0]  e;
    int          off;
    v = 24'h1B2DE4;
    wr(`GPW_OFS_SRC0, v[7:0]);
    wr(`GPW_OFS_SRC1, v[15:8]);
    wr(`GPW_OFS_SRC2, v[23:16]);
    for (int p = 0; p < NP; p++) wr(5'(3 * p + 1), 8'h00);
    settle();
    for (int p = 0; p < NP; p++) begin
      m = (p == 3) ? 8'h03 : 8'hFF;
      chk(oe[p] & m, m);
      for (int b = 0; b < ((p == 3) ? 2 : 8); b++) begin
        off = (p / 2) * 8 + (p % 2) * 4 + ((b >= 4 && p != 3) ? 2 : 0);
        e = 8'(v[off +: 2]);
        chk(8'(lvl[p][b]), e);
      end
    end
    // port a still an output here, so its data read is the latch
    rd(5'h00, 8'hFF);
    // inputs carry no drive level
    wr(5'h01, 8'hFF);
    settle();
    for (int b = 0; b < 8; b++) chk(8'(lvl[0][b]), 8'h00);
    chk(oe[0], 8'h00);
  endtask

  task automatic t_latch;
    wr(5'h03, 8'hA5);
    @(posedge clk);
    sw_on[1] <= 8'hFF;
    sw[1] <= 8'h5A;
    settle();
    chk(opin[1], 8'hA5);
    @(posedge clk);
    clash <= 1'b1;
    settle();
    rd(5'h03, 8'hA5);
    @(posedge clk);
    clash <= 1'b0;
  endtask

  task automatic t_input;
    wr(5'h0D, 8'hFF);
    @(posedge clk);
    sw_on[4] <= 8'hFF;
    sw[4] <= 8'h3C;
    settle();
    rd(5'h0C, 8'h3C);
    @(posedge clk);
    sw[4] <= 8'hC3;
    settle();
    rd(5'h0C, 8'hC3);
  endtask

  task automatic t_pull;
    wr(5'h08, 8'hFF);
    wr(`GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT, 8'h01);
    settle();
    chk(pu[2], 8'h00);
    @(posedge clk);
    od[2] <= 8'hF0;
    settle();
    chk(pu[2], 8'hF0);
    chk(pus[2], 8'hF0);
    wr(5'h07, 8'hFF);
    settle();
    chk(pu[2], 8'hFF);
    chk(oe[2], 8'h00);
    wr(`GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT, 8'h00);
    settle();
    chk(pus[2], 8'h00);
    wr(5'h08, 8'h00);
    wr(`GPW_OFS_LOW_VOLTAGE_PULLUP_SELECT, 8'h01);
    settle();
    chk(pu[2], 8'h00);
    chk(pus[2], 8'h00);
    @(posedge clk);
    od[2] <= 8'h00;
  endtask

  task automatic fall(input logic [7:0] to, input int exp);
    int n;
    n = 0;
    @(posedge clk);
    sw[0] <= 8'hFF;
    settle();
    @(posedge clk);
    sw[0] <= to;
    repeat (8) begin
      @(negedge clk);
      if (wake === 1'b1) n++;
    end
    chk(8'(n), 8'(exp));
  endtask

  task automatic t_wake;
    wr(`GPW_OFS_WAKE, 8'h01);
    @(posedge clk);
    sw_on[0] <= 8'hFF;
    sw[0] <= 8'hFF;
    lowp <= 1'b1;
    fall(8'hFE, 1);
    fall(8'hFD, 0);
    fall(8'hFC, 1);
    @(posedge clk);
    lowp <= 1'b0;
    fall(8'hFE, 0);
  endtask

  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_regs();
    t_src();
    t_latch();
    t_input();
    t_pull();
    t_wake();
    report_and_stop();
  end
endmodule
